// File: src/ormpl_top.sv
// Purpose: Decoder and executor for OR, move and pointer-load words
// Assumes: Data memory answers a read one clock after dmem_rd
// Notes: Four mclk per instruction cycle, Avalon-MM register access
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "ormpl_consts.svh"

module ormpl_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  output logic instr_ready,
  output logic [11:0] dmem_addr,
  output logic dmem_rd,
  output logic dmem_wr,
  output logic [7:0] dmem_wdata,
  input wire logic [7:0] dmem_rdata
);
  import ormpl_pkg::*;

  logic rst_meta_n;
  logic rst_sync_n;
  logic q1;
  logic q2;
  logic q3;
  logic q4;
  ormpl_state_t state;
  ormpl_state_t next_state;
  logic [15:0] ir;
  logic [15:0] next_ir;
  logic expect_second;
  logic next_expect_second;
  ormpl_ptr_sel_t ptr_sel;
  ormpl_ptr_sel_t next_ptr_sel;
  logic [7:0] result;
  logic [7:0] next_result;
  logic [11:0] next_dmem_addr;
  logic next_dmem_rd;
  logic next_dmem_wr;
  logic [7:0] next_dmem_wdata;
  logic [7:0] acc;
  logic [7:0] next_acc;
  logic [3:0] bank_select_register;
  logic [3:0] next_bank;
  logic ext_en;
  logic next_ext_en;
  logic flag_n;
  logic flag_z;
  logic next_flag_n;
  logic next_flag_z;
  logic bad_word;
  logic next_bad_word;
  logic unsup;
  logic next_unsup;
  logic ack;
  logic next_ack;
  logic [31:0] next_readdata;
  logic [35:0] ptr_flat;
  logic [11:0] ptr_index;
  logic [5:0] op_hi;
  logic op_bank;
  logic [7:0] op_file;
  logic [11:0] ea;
  logic byte_op;
  logic wr_high;
  logic wr_low;
  logic bus_wr;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  ormpl_q_phase u_phase (
    .mclk(mclk),
    .rst_n(rst_sync_n),
    .q1(q1),
    .q2(q2),
    .q3(q3),
    .q4(q4)
  );

  ormpl_pointer_file u_ptr (
    .mclk(mclk),
    .rst_n(rst_sync_n),
    .wr_high(wr_high),
    .wr_low(wr_low),
    .sel(ptr_sel),
    .wdata(result),
    .ptr_flat(ptr_flat)
  );

  // Word fields of the incoming first word
  assign ptr_index = ptr_flat[`ORMPL_PTR_INDEX*12 +: 12];
  assign op_hi = instr_word[15:10];
  assign op_bank = instr_word[8];
  assign op_file = instr_word[7:0];
  assign instr_ready = q1;
  assign byte_op = (state == ORMPL_ST_OR) || (state == ORMPL_ST_MOV);

  // Effective data address of a byte instruction
  always_comb begin
    if (op_bank) begin
      ea = {bank_select_register, op_file};
    end else if (ext_en && (op_file <= `ORMPL_ACCESS_LIMIT)) begin
      ea = ptr_index + {4'h0, op_file};
    end else if (op_file <= `ORMPL_ACCESS_LIMIT) begin
      ea = {`ORMPL_ACCESS_LO_BANK, op_file};
    end else begin
      ea = {`ORMPL_ACCESS_HI_BANK, op_file};
    end
  end

  // Decode at Q1, address and read strobe for Q2
  always_comb begin
    next_state = state;
    next_ir = ir;
    next_expect_second = expect_second;
    next_ptr_sel = ptr_sel;
    next_dmem_addr = dmem_addr;
    next_dmem_rd = 1'b0;
    next_bad_word = bad_word;
    next_unsup = unsup;
    if (q1) begin
      next_state = ORMPL_ST_IDLE;
      if (instr_valid) begin
        next_ir = instr_word;
      end
      if (expect_second && instr_valid) begin
        next_expect_second = 1'b0;
        if (instr_word[15:8] == `ORMPL_OP_PTR2) begin
          next_state = ORMPL_ST_PTR_LOW;
        end else begin
          next_bad_word = 1'b1;
        end
      end else if (!expect_second && instr_valid) begin
        if (op_hi == `ORMPL_OP_OR) begin
          next_state = ORMPL_ST_OR;
          next_dmem_addr = ea;
          next_dmem_rd = 1'b1;
        end else if (op_hi == `ORMPL_OP_MOV) begin
          next_state = ORMPL_ST_MOV;
          next_dmem_addr = ea;
          next_dmem_rd = 1'b1;
        end else if (op_hi == `ORMPL_OP_PTR &&
                     instr_word[5:4] != `ORMPL_PTR_BAD) begin
          next_state = ORMPL_ST_PTR_HIGH;
          next_ptr_sel = instr_word[5:4];
        end else begin
          next_unsup = 1'b1;
        end
      end
    end
    if (q4 && state == ORMPL_ST_PTR_HIGH) begin
      next_expect_second = 1'b1;
    end
    if (bus_wr && avs_address == `ORMPL_REG_STATUS) begin
      // Write one clears, a new event in the same cycle wins unless the flag was already set
      if (avs_writedata[`ORMPL_ST_BADWORD] && !(q1 && next_bad_word &&
          !bad_word)) begin
        next_bad_word = 1'b0;
      end
      if (avs_writedata[`ORMPL_ST_UNSUP] && !(q1 && next_unsup &&
          !unsup)) begin
        next_unsup = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ORMPL_ST_IDLE;
      ir <= 16'h0000;
      expect_second <= 1'b0;
      ptr_sel <= 2'h0;
      dmem_addr <= 12'h000;
      dmem_rd <= 1'b0;
      bad_word <= 1'b0;
      unsup <= 1'b0;
    end else begin
      state <= next_state;
      ir <= next_ir;
      expect_second <= next_expect_second;
      ptr_sel <= next_ptr_sel;
      dmem_addr <= next_dmem_addr;
      dmem_rd <= next_dmem_rd;
      bad_word <= next_bad_word;
      unsup <= next_unsup;
    end
  end

  // Process at Q3, memory write strobe for Q4
  always_comb begin
    next_result = result;
    next_dmem_wr = 1'b0;
    next_dmem_wdata = dmem_wdata;
    if (q3) begin
      case (state)
        ORMPL_ST_OR: begin
          next_result = acc | dmem_rdata;
        end
        ORMPL_ST_MOV: begin
          next_result = dmem_rdata;
        end
        ORMPL_ST_PTR_HIGH: begin
          next_result = {4'h0, ir[3:0]};
        end
        ORMPL_ST_PTR_LOW: begin
          next_result = ir[7:0];
        end
        default: begin
          next_result = result;
        end
      endcase
      if (byte_op && ir[9]) begin
        next_dmem_wr = 1'b1;
        next_dmem_wdata = next_result;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      result <= `ORMPL_RST_BYTE;
      dmem_wr <= 1'b0;
      dmem_wdata <= `ORMPL_RST_BYTE;
    end else begin
      result <= next_result;
      dmem_wr <= next_dmem_wr;
      dmem_wdata <= next_dmem_wdata;
    end
  end

  // Q4 pointer half writes
  assign wr_high = q4 && (state == ORMPL_ST_PTR_HIGH);
  assign wr_low = q4 && (state == ORMPL_ST_PTR_LOW);

  // Architectural state, core commit at Q4 wins over bus write
  assign bus_wr = avs_write && ack;
  always_comb begin
    next_acc = acc;
    next_bank = bank_select_register;
    next_ext_en = ext_en;
    next_flag_n = flag_n;
    next_flag_z = flag_z;
    if (bus_wr) begin
      case (avs_address)
        `ORMPL_REG_CTRL: next_ext_en = avs_writedata[0];
        `ORMPL_REG_ACC: next_acc = avs_writedata[7:0];
        `ORMPL_REG_BANK: next_bank = avs_writedata[3:0];
        default: next_ext_en = ext_en;
      endcase
    end
    if (q4 && byte_op) begin
      if (!ir[9]) begin
        next_acc = result;
      end
      next_flag_n = result[7];
      next_flag_z = (result == 8'h00);
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      acc <= `ORMPL_RST_BYTE;
      bank_select_register <= `ORMPL_RST_NIB;
      ext_en <= 1'b0;
      flag_n <= 1'b0;
      flag_z <= 1'b0;
    end else begin
      acc <= next_acc;
      bank_select_register <= next_bank;
      ext_en <= next_ext_en;
      flag_n <= next_flag_n;
      flag_z <= next_flag_z;
    end
  end

  // Avalon slave: one wait cycle, read data registered
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  always_comb begin
    next_ack = (avs_read || avs_write) && !ack;
    next_readdata = avs_readdata;
    if (avs_read && !ack) begin
      case (avs_address)
        `ORMPL_REG_CTRL: next_readdata = {31'h0, ext_en};
        `ORMPL_REG_ACC: next_readdata = {24'h0, acc};
        `ORMPL_REG_BANK: next_readdata = {28'h0, bank_select_register};
        `ORMPL_REG_STATUS: next_readdata = {28'h0, unsup, bad_word,
                                            flag_n, flag_z};
        `ORMPL_REG_PTR0: next_readdata = {20'h0, ptr_flat[0 +: 12]};
        `ORMPL_REG_PTR1: next_readdata = {20'h0, ptr_flat[12 +: 12]};
        `ORMPL_REG_PTR2: next_readdata = {20'h0, ptr_flat[24 +: 12]};
        default: next_readdata = `ORMPL_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ack <= 1'b0;
      avs_readdata <= `ORMPL_RST_WORD;
    end else begin
      ack <= next_ack;
      avs_readdata <= next_readdata;
    end
  end

  // Checks on the datapath
  AST_OR_RESULT: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (q3 && state == ORMPL_ST_OR) |=> (result == $past(acc | dmem_rdata)))
    else $error("OR result wrong");
  AST_ACC_DEST: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (q4 && byte_op && !ir[9]) |=> (acc == $past(result)))
    else $error("Accumulator not written");
  AST_MEM_DEST: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (q2 && byte_op) ##1 q3 |=> (dmem_wr == ir[9]) && q4)
    else $error("Memory write strobe wrong");
  AST_ACCESS_BANK: assert property (@(posedge mclk)
    disable iff (!rst_sync_n)
    (dmem_rd && !ir[8] && !$past(ext_en)) |->
    (dmem_addr[11:8] == ((ir[7:0] <= `ORMPL_ACCESS_LIMIT) ?
     `ORMPL_ACCESS_LO_BANK : `ORMPL_ACCESS_HI_BANK)))
    else $error("Access bank address wrong");
  AST_BANKED: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (dmem_rd && ir[8]) |->
    (dmem_addr == {$past(bank_select_register), ir[7:0]}))
    else $error("Banked address wrong");
  AST_INDEXED: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (dmem_rd && !ir[8] && $past(ext_en) &&
     ir[7:0] <= `ORMPL_ACCESS_LIMIT) |->
    (dmem_addr == $past(ptr_index) + {4'h0, ir[7:0]}))
    else $error("Indexed address wrong");
  AST_PTR_LOW: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (q4 && state == ORMPL_ST_PTR_LOW) |=>
    (ptr_flat[ptr_sel*12 +: 8] == ir[7:0]))
    else $error("Pointer low byte wrong");
  AST_MOV_COPY: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (q3 && state == ORMPL_ST_MOV) |=> (result == $past(dmem_rdata)))
    else $error("Move result wrong");
  AST_FLAGS: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    (q4 && state == ORMPL_ST_PTR_HIGH) |=> $stable(flag_z) &&
    $stable(flag_n) && (ptr_flat[ptr_sel*12 + 8 +: 4] == ir[3:0]))
    else $error("Pointer load touched flags");
  AST_BUS_WAIT: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    avs_waitrequest |=> !avs_waitrequest)
    else $error("Wait longer than one cycle");
endmodule

// File: common/ormpl_consts.svh
// Purpose: Shared constants of the OR, move and pointer-load decoder
// Assumes: Included by bare name from every design file
// Notes: Definitions only
`ifndef ORMPL_CONSTS_SVH
`define ORMPL_CONSTS_SVH

// Phase codes of the four-phase instruction cycle
`define ORMPL_PH_Q1 2'h0
`define ORMPL_PH_Q2 2'h1
`define ORMPL_PH_Q3 2'h2
`define ORMPL_PH_Q4 2'h3

// Opcode prefixes, upper six bits of the first word
`define ORMPL_OP_OR 6'h04
`define ORMPL_OP_MOV 6'h14
`define ORMPL_OP_PTR 6'h38
// Upper eight bits of the second pointer-load word
`define ORMPL_OP_PTR2 8'hF0

// Data addressing
`define ORMPL_ACCESS_LIMIT 8'h5F
`define ORMPL_ACCESS_HI_BANK 4'hF
`define ORMPL_ACCESS_LO_BANK 4'h0
`define ORMPL_PTR_INDEX 2'h2
`define ORMPL_PTR_BAD 2'h3

// Register word indices on the bus
`define ORMPL_REG_CTRL 3'h0
`define ORMPL_REG_ACC 3'h1
`define ORMPL_REG_BANK 3'h2
`define ORMPL_REG_STATUS 3'h3
`define ORMPL_REG_PTR0 3'h4
`define ORMPL_REG_PTR1 3'h5
`define ORMPL_REG_PTR2 3'h6

// Status bit positions
`define ORMPL_ST_Z 0
`define ORMPL_ST_N 1
`define ORMPL_ST_BADWORD 2
`define ORMPL_ST_UNSUP 3

// Reset values
`define ORMPL_RST_BYTE 8'h00
`define ORMPL_RST_NIB 4'h0
`define ORMPL_RST_PTR 12'h000
`define ORMPL_RST_WORD 32'h00000000

`endif

// File: common/ormpl_pkg.sv
// Purpose: Types of the OR, move and pointer-load decoder
// Assumes: Constants come from ormpl_consts.svh
// Notes: Types only
package ormpl_pkg;

  // Operation carried out in the current instruction cycle
  typedef enum logic [2:0] {
    ORMPL_ST_IDLE,
    ORMPL_ST_OR,
    ORMPL_ST_MOV,
    ORMPL_ST_PTR_HIGH,
    ORMPL_ST_PTR_LOW
  } ormpl_state_t;

  typedef logic [1:0] ormpl_ptr_sel_t;

endpackage

// File: src/ormpl_q_phase.sv
// Purpose: Four-phase instruction clock divider
// Assumes: One mclk per phase, phase Q1 right after reset
// Notes: Outputs are one-cycle enable pulses
`timescale 1ns/10ps
`include "ormpl_consts.svh"

module ormpl_q_phase (
  input wire logic mclk,
  input wire logic rst_n,
  output logic q1,
  output logic q2,
  output logic q3,
  output logic q4
);
  import ormpl_pkg::*;

  logic [1:0] phase;
  logic [1:0] next_phase;

  // Phase counter wraps every four clocks
  always_comb begin
    next_phase = phase + 2'h1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= `ORMPL_PH_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  // Phase decode
  assign q1 = (phase == `ORMPL_PH_Q1);
  assign q2 = (phase == `ORMPL_PH_Q2);
  assign q3 = (phase == `ORMPL_PH_Q3);
  assign q4 = (phase == `ORMPL_PH_Q4);
endmodule

// File: src/ormpl_pointer_file.sv
// Purpose: Three 12-bit indirect address pointers
// Assumes: One byte-half write per cycle
// Notes: Read data come straight from the pointer flops
`timescale 1ns/10ps
`include "ormpl_consts.svh"

module ormpl_pointer_file (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr_high,
  input wire logic wr_low,
  input wire ormpl_pkg::ormpl_ptr_sel_t sel,
  input wire logic [7:0] wdata,
  output logic [35:0] ptr_flat
);
  import ormpl_pkg::*;

  genvar gi;

  // One pointer per entry
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_ptr
      logic [11:0] ptr;
      logic [11:0] next_ptr;
      always_comb begin
        next_ptr = ptr;
        if (wr_high && (sel == 2'(gi))) begin
          next_ptr = {wdata[3:0], ptr[7:0]};
        end else if (wr_low && (sel == 2'(gi))) begin
          next_ptr = {ptr[11:8], wdata};
        end
      end
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          ptr <= `ORMPL_RST_PTR;
        end else begin
          ptr <= next_ptr;
        end
      end
      assign ptr_flat[gi*12 +: 12] = ptr;
    end
  endgenerate
endmodule

// File: test/ormpl_dmem_model.sv
// Purpose: Banked data memory model on the far side of the decoder
// Assumes: Read data answer one cycle after the read strobe
// Notes: Rdata toggles when not read, so stale data never pass
`timescale 1ns/10ps

module ormpl_dmem_model (
  input wire logic mclk,
  input wire logic [11:0] dmem_addr,
  input wire logic dmem_rd,
  input wire logic dmem_wr,
  input wire logic [7:0] dmem_wdata,
  output logic [7:0] dmem_rdata
);
  logic [7:0] mem [0:4095];

  // Clear the whole 4096-byte space
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'h00;
    end
    dmem_rdata = 8'h00;
  end

  // One-cycle read, byte write, inverted data when idle
  always @(posedge mclk) begin
    if (dmem_rd) begin
      dmem_rdata <= mem[dmem_addr];
    end else begin
      dmem_rdata <= ~dmem_rdata;
    end
    if (dmem_wr) begin
      mem[dmem_addr] <= dmem_wdata;
    end
  end
endmodule

// File: test/ormpl_top_tb_top.sv
// Purpose: Self-checking bench of the OR, move and pointer-load decoder
// Assumes: Avalon-MM access with one wait state, memory model partner
// Notes: Registers 0 ctrl, 1 acc, 2 bank, 3 status, 4..6 pointers
`timescale 1ns/10ps
`include "ormpl_consts.svh"

module ormpl_top_tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] instr_word = 16'h0;
  logic instr_valid = 1'b0;
  logic instr_ready;
  logic [11:0] dmem_addr;
  logic dmem_rd;
  logic dmem_wr;
  logic [7:0] dmem_wdata;
  logic [7:0] dmem_rdata;
  int errors = 0;
  int n_tests = 0;
  logic [31:0] rd;

  ormpl_top DUT (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .instr_word(instr_word),
    .instr_valid(instr_valid), .instr_ready(instr_ready),
    .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr),
    .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata));

  ormpl_dmem_model mem_model (.mclk(mclk), .dmem_addr(dmem_addr),
    .dmem_rd(dmem_rd), .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata),
    .dmem_rdata(dmem_rdata));

  // Clock of 8 ns
  initial begin
    forever #4 mclk = ~mclk;
  end

  // Verdict and end of run
  task automatic end_sim();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compare one value
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 16) begin
      errors++;
      end_sim();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Read a register and compare it
  task automatic rchk(input string what, input logic [2:0] a,
                      input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  // Hand one program word over at a Q1 cycle, then let it finish
  task automatic issue(input logic [15:0] w);
    int i;
    @(posedge mclk);
    instr_word <= w;
    instr_valid <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk);
      if (instr_ready === 1'b1) break;
    end
    if (i == 16) begin
      errors++;
      end_sim();
    end
    instr_valid <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  // Main sequence
  initial begin
    logic [11:0] k [0:2];
    k[0] = 12'hC05;
    k[1] = 12'h0FF;
    k[2] = 12'h3AB;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    // Reset values and unmapped index
    rchk("ctrl", `ORMPL_REG_CTRL, 32'h0);
    rchk("acc", `ORMPL_REG_ACC, 32'h0);
    rchk("status", `ORMPL_REG_STATUS, 32'h0);
    rchk("ptr0", `ORMPL_REG_PTR0, 32'h0);
    bus(1'b1, 3'h7, 32'hFF);
    rchk("unmapped", 3'h7, 32'h0);
    // OR, result to accumulator, banked address
    mem_model.mem[12'h291] = 8'h91;
    bus(1'b1, `ORMPL_REG_ACC, 32'h13);
    bus(1'b1, `ORMPL_REG_BANK, 32'h2);
    issue(16'h1191);
    rchk("acc or", `ORMPL_REG_ACC, 32'h93);
    check("mem 291", mem_model.mem[12'h291], 32'h91);
    rchk("status n", `ORMPL_REG_STATUS, 32'h2);
    // OR back to memory, upper access bank
    mem_model.mem[12'hF80] = 8'h0F;
    issue(16'h1280);
    check("mem F80", mem_model.mem[12'hF80], 32'h9F);
    rchk("acc kept", `ORMPL_REG_ACC, 32'h93);
    // Move a zero byte from the lower access bank
    issue(16'h5022);
    rchk("acc mov", `ORMPL_REG_ACC, 32'h0);
    rchk("status z", `ORMPL_REG_STATUS, 32'h1);
    // Move from the top of the bank, to W and back to the file
    mem_model.mem[12'h2FF] = 8'h5A;
    issue(16'h51FF);
    rchk("acc ff", `ORMPL_REG_ACC, 32'h5A);
    issue(16'h53FF);
    check("mem 2FF", mem_model.mem[12'h2FF], 32'h5A);
    rchk("status clr", `ORMPL_REG_STATUS, 32'h0);
    // Zero byte back to file sets Z, so the loads must keep it
    issue(16'h5322);
    // Pointer loads, high half visible before the second word
    for (int f = 0; f < 3; f++) begin
      issue(16'hE000 | 16'(f << 4) | 16'(k[f][11:8]));
      rchk("ptr half", 3'(4 + f), {20'h0, k[f][11:8], 8'h00});
      issue(16'hF000 | 16'(k[f][7:0]));
      rchk("ptr full", 3'(4 + f), {20'h0, k[f]});
    end
    rchk("status ptr", `ORMPL_REG_STATUS, 32'h1);
    // Indexed literal offset through pointer 2, limit 5Fh
    mem_model.mem[12'h3B0] = 8'h81;
    mem_model.mem[12'h40A] = 8'h20;
    mem_model.mem[12'hF60] = 8'h04;
    bus(1'b1, `ORMPL_REG_CTRL, 32'h1);
    issue(16'h1005);
    rchk("acc idx", `ORMPL_REG_ACC, 32'hDB);
    issue(16'h105F);
    rchk("acc 5F", `ORMPL_REG_ACC, 32'hFB);
    issue(16'h1060);
    rchk("acc 60", `ORMPL_REG_ACC, 32'hFF);
    bus(1'b1, `ORMPL_REG_CTRL, 32'h0);
    // Unsupported words, pointer select 3, sticky clear
    issue(16'hFFFF);
    rchk("status us", `ORMPL_REG_STATUS, 32'hA);
    bus(1'b1, `ORMPL_REG_STATUS, 32'h8);
    issue(16'hE031);
    rchk("status p3", `ORMPL_REG_STATUS, 32'hA);
    bus(1'b1, `ORMPL_REG_STATUS, 32'h8);
    rchk("status w1c", `ORMPL_REG_STATUS, 32'h2);
    // Bad second pointer word abandons the load
    issue(16'hE001);
    issue(16'h0000);
    bus(1'b0, `ORMPL_REG_STATUS, 32'h0);
    check("bad word", rd & 32'h4, 32'h4);
    rchk("ptr0 half", `ORMPL_REG_PTR0, 32'h105);
    end_sim();
  end
endmodule
